// >>> jsw_config_regs.sv
`timescale 1ns/1ns
// Summary of operation
// - Aux ports slave-driven per mode pins: 00 bit, 01 yes, 10 no, 11 none.
// - Deselect drive bit clear: mode select low, reset high, data low, clock low.
// - Deselect drive bit set: mode select and data float; reset high, clock low.
// - Deselect drive bit ignored for slave-driven aux ports; only their mode select floats, during a presence scan.
// - Port deselected in configuration mode or when its address is not selected.
// - Deselect drive bit always shown on its own output pin.
// - Configuration bit 3 inverts mode select towards the selected port.
// - Configuration bit 2 inverts serial data towards the selected port.
// - Configuration bit 1 inverts returned data towards the master.
// - Configuration bit 0 inverts the forwarded test clock.
// - Each pin has a two-bit mode: input, drive low, drive high, reserved.
// - Pin sense bits 3..0 report levels of pins 3..0.
// - Identification reads fixed pattern high nibble, revision low nibble.
// - Presence scan records ports 1..18 whose mode select reads high.
// - Presence bits 18, 19 for aux ports, sensed only when slave-capable.
// - Selection code 1..18 plain ports, 19..20 aux, others select none.
// - Indicator outputs carry inverted port number, all ones when none.
// - Ports 19 and 20 selectable only when that aux port is slave-capable.
// - Writes shift old contents out; read-only registers ignore writes.
module jsw_config_regs #(
    parameter logic [3:0] FIXED_PATTERN = 4'hA, // Arbitrary value
    parameter logic [3:0] REVISION = 4'h1 // Arbitrary value
) (
    input wire logic clk,
    input wire logic nrst,
    // Master side test pins
    input wire logic master_clock,
    input wire logic master_mode_select,
    input wire logic master_data_in,
    output logic master_data_out,
    // From the TAP decoder, same clock
    input wire logic config_mode,
    input wire logic [4:0] instruction,
    input wire logic capture_dr,
    input wire logic shift_dr,
    input wire logic update_dr,
    input wire logic presence_scan_cmd,
    // Package mode pins
    input wire logic [1:0] package_mode,
    // Secondary ports, index 18 and 19 are the aux master ports
    input wire logic [19:0] port_mode_select_in,
    input wire logic [19:0] port_data_return,
    output logic [19:0] port_mode_select_out,
    output logic [19:0] port_mode_select_oe,
    output logic [19:0] port_serial_data_out,
    output logic [19:0] port_serial_data_oe,
    output logic [19:0] port_test_reset_out,
    output logic [19:0] port_clock_out,
    output logic [1:0] aux_master_oe,
    output logic [4:0] port_select_indicator_n,
    output logic deselect_drive_select,
    // General-purpose pins
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe
);
    logic [5:0] path_configuration;
    logic [7:0] pin_mode_control;
    logic [3:0] pin_sense;
    logic [19:0] port_presence;
    logic [4:0] port_selection;
    logic [1:0] mode_pins;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_d;
    logic [19:0] msel_s;
    logic [19:0] ret_s;
    logic [3:0] pin_s;
    logic tck_rise;
    logic tck_fall;
    logic [19:0] shift_capture;
    logic [19:0] shift_result;
    logic shift_write;
    logic shift_tdo;
    logic [4:0] shift_width;
    logic slave_capable;
    logic select_valid;
    logic [4:0] port_select_code;
    logic [3:0] pin_drive;
    logic [3:0] pin_drive_en;
    logic [19:0] port_hit;
    logic fwd_tms;
    logic fwd_tdi;
    logic fwd_tck;
    logic sel_return;

    jsw_sync #(.W(3)) u_master_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({master_clock, master_mode_select, master_data_in}),
        .sync_out({tck_s, tms_s, tdi_s})
    );

    jsw_sync #(.W(46)) u_pin_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in({package_mode, port_mode_select_in, port_data_return, pin_in}),
        .sync_out({mode_pins, msel_s, ret_s, pin_s})
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tck_s;
        end
    end

    assign tck_rise = tck_s && !tck_d;
    assign tck_fall = !tck_s && tck_d;

    always_comb begin
        unique case (mode_pins)
            jsw_pkg::MODE_SINGLE: slave_capable = path_configuration[jsw_pkg::CFG_SLAVE_DRIVE];
            jsw_pkg::MODE_CASCADE_MASTER: slave_capable = 1'b1;
            jsw_pkg::MODE_CASCADE_EXT: slave_capable = 1'b0;
            jsw_pkg::MODE_DESELECT: slave_capable = 1'b0;
        endcase
    end

    function automatic logic code_valid(input logic [4:0] code, input logic aux_ok);
        logic plain;
        logic aux;
        plain = code != 5'h00 && code <= 5'(jsw_pkg::PLAIN_PORTS);
        aux = code == jsw_pkg::PORT_AUX_ONE || code == jsw_pkg::PORT_AUX_TWO;
        return plain || (aux && aux_ok);
    endfunction : code_valid

    // aux codes only count when slave-capable
    assign select_valid = code_valid(port_selection, slave_capable);
    assign port_select_code = port_selection;

    // reserved code and input code leave the pin undriven
    function automatic logic pin_driven(input logic [1:0] field);
        return field == jsw_pkg::PIN_DRIVE_LOW || field == jsw_pkg::PIN_DRIVE_HIGH;
    endfunction : pin_driven

    always_comb begin
        for (int n = 0; n < 4; n++) begin
            pin_drive_en[n] = pin_driven(pin_mode_control[2*n +: 2]);
            pin_drive[n] = pin_mode_control[2*n +: 2] == jsw_pkg::PIN_DRIVE_HIGH;
        end
    end

    // Register view presented to the shift path at capture
    always_comb begin
        shift_capture = '0;
        shift_width = 5'(jsw_pkg::IDENT_W);
        unique case (instruction)
            jsw_pkg::INSTR_PRESENCE: begin
                shift_capture = port_presence;
                shift_width = 5'(jsw_pkg::PRESENCE_W);
            end
            jsw_pkg::INSTR_SELECT: begin
                shift_capture[4:0] = port_selection;
                shift_width = 5'(jsw_pkg::SELECT_W);
            end
            jsw_pkg::INSTR_PIN_MODE: begin
                shift_capture[7:0] = pin_mode_control;
                shift_width = 5'(jsw_pkg::PIN_MODE_W);
            end
            jsw_pkg::INSTR_PIN_SENSE: begin
                shift_capture[3:0] = pin_sense;
                shift_width = 5'(jsw_pkg::PIN_SENSE_W);
            end
            jsw_pkg::INSTR_CONFIG: begin
                shift_capture[5:0] = path_configuration;
                shift_width = 5'(jsw_pkg::CONFIG_W);
            end
            default: begin
                shift_capture[7:0] = {FIXED_PATTERN, REVISION};
            end
        endcase
    end

    jsw_shifter u_shifter (
        .clk(clk),
        .nrst(nrst),
        .tck_rise(tck_rise),
        .tck_fall(tck_fall),
        .capture(config_mode && capture_dr),
        .shift(config_mode && shift_dr),
        .update(config_mode && update_dr),
        .serial_in(tdi_s),
        .width(shift_width),
        .parallel_in(shift_capture),
        .parallel_out(shift_result),
        .write_pulse(shift_write),
        .serial_out(shift_tdo)
    );

    // only writable registers take the shifted value
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            path_configuration <= jsw_pkg::CONFIG_RESET;
            pin_mode_control <= jsw_pkg::PIN_MODE_RESET;
            port_selection <= jsw_pkg::SELECT_RESET;
        end else if (shift_write) begin
            if (instruction == jsw_pkg::INSTR_CONFIG) begin
                path_configuration <= shift_result[5:0];
            end
            if (instruction == jsw_pkg::INSTR_PIN_MODE) begin
                pin_mode_control <= shift_result[7:0];
            end
            if (instruction == jsw_pkg::INSTR_SELECT) begin
                port_selection <= shift_result[4:0];
            end
        end
    end

    // sense sampled every cycle while the read instruction is selected, held once shifting starts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_sense <= jsw_pkg::PIN_SENSE_RESET;
        end else if (config_mode && instruction == jsw_pkg::INSTR_PIN_SENSE && !shift_dr) begin
            for (int n = 0; n < 4; n++) begin
                pin_sense[n] <= pin_drive_en[n] ? pin_drive[n] : pin_s[n];
            end
        end
    end

    // Sampled every cycle while the scan runs, so the last settled level is kept
    // plain port presence
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_presence <= jsw_pkg::PRESENCE_RESET;
        end else if (presence_scan_cmd) begin
            port_presence[17:0] <= msel_s[17:0];
            // aux presence gated by slave capability
            port_presence[19:18] <= slave_capable ? msel_s[19:18] : 2'b00;
        end
    end

    always_comb begin
        for (int n = 0; n < jsw_pkg::PORT_COUNT; n++) begin
            port_hit[n] = !config_mode && select_valid && port_select_code == 5'(n + 1);
        end
    end

    assign fwd_tms = tms_s ^ path_configuration[jsw_pkg::CFG_MODE_SEL_INV];
    assign fwd_tdi = tdi_s ^ path_configuration[jsw_pkg::CFG_DATA_IN_INV];
    assign fwd_tck = tck_s ^ path_configuration[jsw_pkg::CFG_CLOCK_INV];
    assign sel_return = |(port_hit & ret_s);

    // Registered outputs add a few cycles of skew; all four lines share it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_mode_select_out <= '0;
            port_serial_data_out <= '0;
            port_test_reset_out <= '1;
            port_clock_out <= '0;
            port_mode_select_oe <= '0;
            port_serial_data_oe <= '0;
            aux_master_oe <= '0;
        end else begin
            for (int n = 0; n < jsw_pkg::PORT_COUNT; n++) begin
                port_mode_select_out[n] <= port_hit[n] && fwd_tms;
                port_serial_data_out[n] <= port_hit[n] && fwd_tdi;
                port_clock_out[n] <= port_hit[n] && fwd_tck;
                port_test_reset_out[n] <= 1'b1;
                // float when deselect drive bit set
                port_mode_select_oe[n] <= port_hit[n] ||
                    !path_configuration[jsw_pkg::CFG_DESELECT_DRIVE];
                port_serial_data_oe[n] <= port_hit[n] ||
                    !path_configuration[jsw_pkg::CFG_DESELECT_DRIVE];
            end
            for (int a = 0; a < 2; a++) begin
                port_mode_select_oe[18 + a] <= slave_capable;
                port_serial_data_oe[18 + a] <= slave_capable;
                aux_master_oe[a] <= slave_capable;
            end
            // mode select lines become inputs while scanning
            if (presence_scan_cmd) begin
                port_mode_select_oe <= '0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            master_data_out <= 1'b0;
        end else if (config_mode) begin
            master_data_out <= shift_tdo;
        end else begin
            master_data_out <= sel_return ^ path_configuration[jsw_pkg::CFG_DATA_OUT_INV];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_select_indicator_n <= jsw_pkg::SELECT_NONE_IND;
        end else begin
            port_select_indicator_n <= select_valid ? ~port_select_code : jsw_pkg::SELECT_NONE_IND;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            deselect_drive_select <= 1'b0;
        end else begin
            deselect_drive_select <= path_configuration[jsw_pkg::CFG_DESELECT_DRIVE];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_out <= pin_drive;
            pin_oe <= pin_drive_en;
        end
    end
endmodule : jsw_config_regs

// >>> jsw_pkg.sv
package jsw_pkg;
    // Instruction codes that address each register through the switch TAP
    localparam logic [4:0] INSTR_IDENT = 5'h00;
    localparam logic [4:0] INSTR_PRESENCE = 5'h01;
    localparam logic [4:0] INSTR_SELECT = 5'h02;
    localparam logic [4:0] INSTR_PIN_MODE = 5'h03;
    localparam logic [4:0] INSTR_PIN_SENSE = 5'h04;
    localparam logic [4:0] INSTR_CONFIG = 5'h05;

    // Register widths
    localparam int IDENT_W = 8;
    localparam int CONFIG_W = 6;
    localparam int PIN_MODE_W = 8;
    localparam int PIN_SENSE_W = 4;
    localparam int PRESENCE_W = 20;
    localparam int SELECT_W = 5;
    localparam int SHIFT_W = 20;

    // Path configuration fields
    localparam int CFG_CLOCK_INV = 0;
    localparam int CFG_DATA_OUT_INV = 1;
    localparam int CFG_DATA_IN_INV = 2;
    localparam int CFG_MODE_SEL_INV = 3;
    localparam int CFG_DESELECT_DRIVE = 4;
    localparam int CFG_SLAVE_DRIVE = 5;

    // Reset values
    localparam logic [5:0] CONFIG_RESET = 6'h00;
    localparam logic [7:0] PIN_MODE_RESET = 8'h00;
    localparam logic [3:0] PIN_SENSE_RESET = 4'h0;
    localparam logic [19:0] PRESENCE_RESET = 20'h00000;
    localparam logic [4:0] SELECT_RESET = 5'h00;

    // Package mode pin codes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_CASCADE_MASTER = 2'h1;
    localparam logic [1:0] MODE_CASCADE_EXT = 2'h2;
    localparam logic [1:0] MODE_DESELECT = 2'h3;

    // Pin mode field codes
    localparam logic [1:0] PIN_INPUT = 2'h0;
    localparam logic [1:0] PIN_DRIVE_LOW = 2'h1;
    localparam logic [1:0] PIN_DRIVE_HIGH = 2'h2;
    localparam logic [1:0] PIN_RESERVED = 2'h3;

    // Port numbering
    localparam int PORT_COUNT = 20;
    localparam int PLAIN_PORTS = 18;
    localparam logic [4:0] PORT_AUX_ONE = 5'h13;
    localparam logic [4:0] PORT_AUX_TWO = 5'h14;
    localparam logic [4:0] SELECT_NONE_IND = 5'h1F;

    typedef enum logic [2:0] {
        SHIFT_IDLE = 3'b001,
        SHIFT_RUN = 3'b010,
        SHIFT_DONE = 3'b100
    } shift_state_e;
endpackage : jsw_pkg

// >>> jsw_sync.sv
`timescale 1ns/1ns
// Three-stage synchroniser; output follows once stages two and three agree
module jsw_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            meta <= async_in;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    end
endmodule : jsw_sync

// >>> jsw_shifter.sv
`timescale 1ns/1ns
// Data register shift path: capture, shift LSB first, hand over on update
module jsw_shifter (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tck_rise,
    input wire logic tck_fall,
    input wire logic capture,
    input wire logic shift,
    input wire logic update,
    input wire logic serial_in,
    input wire logic [4:0] width,
    input wire logic [jsw_pkg::SHIFT_W-1:0] parallel_in,
    output logic [jsw_pkg::SHIFT_W-1:0] parallel_out,
    output logic write_pulse,
    output logic serial_out
);
    logic [jsw_pkg::SHIFT_W-1:0] sreg;
    jsw_pkg::shift_state_e state;

    // New bit enters at the top of the selected register's width
    function automatic logic [jsw_pkg::SHIFT_W-1:0] shift_in(
        input logic [jsw_pkg::SHIFT_W-1:0] cur, input logic bit_in, input logic [4:0] w);
        logic [jsw_pkg::SHIFT_W-1:0] r;
        r = cur >> 1;
        r[w - 5'd1] = bit_in;
        return r;
    endfunction : shift_in

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sreg <= '0;
            state <= jsw_pkg::SHIFT_IDLE;
        end else if (tck_rise) begin
            unique case (state)
                jsw_pkg::SHIFT_IDLE: begin
                    if (capture) begin
                        sreg <= parallel_in;
                        state <= jsw_pkg::SHIFT_RUN;
                    end
                end
                jsw_pkg::SHIFT_RUN: begin
                    if (shift) begin
                        sreg <= shift_in(sreg, serial_in, width);
                    end else if (update) begin
                        state <= jsw_pkg::SHIFT_DONE;
                    end
                end
                jsw_pkg::SHIFT_DONE: begin
                    state <= jsw_pkg::SHIFT_IDLE;
                end
                default: state <= jsw_pkg::SHIFT_IDLE;
            endcase
        end
    end

    // Old contents leave on the falling edge while new ones come in
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serial_out <= 1'b0;
        end else if (tck_fall) begin
            serial_out <= sreg[0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            write_pulse <= 1'b0;
            parallel_out <= '0;
        end else begin
            write_pulse <= tck_rise && state == jsw_pkg::SHIFT_RUN && !shift && update;
            parallel_out <= sreg;
        end
    end
endmodule : jsw_shifter

// >>> jsw_config_regs_checker.sv
`timescale 1ns/1ns
module jsw_config_regs_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic config_mode,
    input wire logic presence_scan_cmd,
    input wire logic [19:0] port_mode_select_out,
    input wire logic [19:0] port_mode_select_oe,
    input wire logic [19:0] port_serial_data_oe,
    input wire logic [19:0] port_test_reset_out,
    input wire logic [19:0] port_clock_out,
    input wire logic [1:0] aux_master_oe,
    input wire logic [4:0] port_select_indicator_n,
    input wire logic deselect_drive_select
);
    logic [1:0] quiet_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Outputs are registered: only judge them a few edges into quiet config mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            quiet_cnt <= 2'h0;
        end else begin
            quiet_cnt <= (!config_mode || presence_scan_cmd) ? 2'h0
                : quiet_cnt + {1'b0, quiet_cnt != 2'h3};
        end
    end
    property p_desel_out;
        quiet_cnt == 2'h3 |-> port_mode_select_out == 20'h0 && port_clock_out == 20'h0;
    endproperty
    a_desel_out: assert property (p_desel_out) else $error("deselected port drives");
    property p_desel_oe;
        quiet_cnt == 2'h3 && $stable(deselect_drive_select) |->
            port_mode_select_oe[17:0] == {18{!deselect_drive_select}}
            && port_serial_data_oe[17:0] == port_mode_select_oe[17:0];
    endproperty
    a_desel_oe: assert property (p_desel_oe) else $error("deselect enable wrong");
    property p_aux_oe;
        quiet_cnt == 2'h3 && $stable(aux_master_oe) |->
            port_mode_select_oe[19:18] == aux_master_oe
            && port_serial_data_oe[19:18] == aux_master_oe;
    endproperty
    a_aux_oe: assert property (p_aux_oe) else $error("aux port enable wrong");
    property p_scan_oe;
        presence_scan_cmd && $past(presence_scan_cmd) |-> port_mode_select_oe == 20'h0;
    endproperty
    a_scan_oe: assert property (p_scan_oe) else $error("mode select driven in scan");
    property p_aux_sel;
        $fell(aux_master_oe[0]) |-> ##[0:3] port_select_indicator_n != 5'h0C;
    endproperty
    a_aux_sel: assert property (p_aux_sel) else $error("aux port kept selected");
    property p_one_clock;
        $onehot0(port_clock_out);
    endproperty
    a_one_clock: assert property (p_one_clock) else $error("several clocks forwarded");
    property p_none_clock;
        (port_select_indicator_n == 5'h1F) [*3] |-> port_clock_out == 20'h0;
    endproperty
    a_none_clock: assert property (p_none_clock) else $error("clock with no port");
    property p_reset_high;
        port_test_reset_out == 20'hFFFFF;
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("port reset low");
    c_aux: cover property (port_select_indicator_n == 5'h0C);
    c_scan: cover property (presence_scan_cmd ##1 !presence_scan_cmd);
    c_float: cover property (quiet_cnt == 2'h3 && deselect_drive_select);
endmodule : jsw_config_regs_checker

// >>> jsw_master_model.sv
`timescale 1ns/1ns
// Test master on the far side; its test clock is left low at the end of each scan
module jsw_master_model (
    input wire logic clk,
    input wire logic master_data_out,
    output logic master_clock,
    output logic master_mode_select,
    output logic master_data_in,
    output logic config_mode,
    output logic [4:0] instruction,
    output logic capture_dr,
    output logic shift_dr,
    output logic update_dr
);
    initial {master_clock, master_mode_select, master_data_in, config_mode, capture_dr,
        shift_dr, update_dr, instruction} = 12'h000;
    // Returned bit is taken just before the fall, while it still stands
    task automatic tick(output logic tdo);
        master_clock = 1'b1;
        repeat (4) @(negedge clk);
        tdo = master_data_out;
        master_clock = 1'b0;
        repeat (4) @(negedge clk);
    endtask : tick
    task automatic scan(input logic [4:0] ins, input int w, input logic [19:0] din,
        output logic [19:0] dout);
        logic b;
        dout = 20'h0;
        // Clock may stand high after a path test; let a low settle so capture sees a rise
        {master_clock, config_mode, instruction, capture_dr} = {1'b0, 1'b1, ins, 1'b1};
        repeat (5) @(negedge clk);
        tick(b);
        {capture_dr, shift_dr} = 2'h1;
        for (int i = 0; i < w; i++) begin
            master_data_in = din[i];
            @(negedge clk);
            tick(dout[i]);
        end
        {shift_dr, update_dr} = 2'h1;
        tick(b);
        update_dr = 1'b0;
        // Idle rise after update, as the TAP passes before the next capture
        tick(b);
    endtask : scan
    task automatic path(input logic ck, ms, di);
        {config_mode, master_clock, master_mode_select, master_data_in} = {1'b0, ck, ms, di};
    endtask : path
endmodule : jsw_master_model

// >>> jsw_config_regs_tb.sv
`timescale 1ns/1ns
module jsw_config_regs_tb;
    localparam logic [3:0] PAT = 4'h5; // Arbitrary value
    localparam logic [3:0] REV = 4'h3; // Arbitrary value
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic scan_cmd = 1'b0;
    logic [1:0] pmode = 2'h0;
    logic [19:0] ms_ext = 20'h0;
    logic [19:0] ret = 20'h0;
    logic [3:0] pin_ext = 4'h0;
    logic [3:0] pin_in, pin_out, pin_oe, es;
    logic mck, mms, mdi, mdo, cmode, cap_dr, sh_dr, up_dr, dsel, cap, drv;
    logic [4:0] ins, ind_n, sel, psel, pn;
    logic [19:0] ms_in, ms_out, ms_oe, sd_out, sd_oe, rst_out, ck_out, rd, e;
    logic [1:0] aux_oe;
    logic [5:0] cfg, pcfg;
    logic [7:0] pm, ppm;
    logic [4:0] corner [10] = '{5'h00, 5'h01, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1F, 5'h12,
        5'h13, 5'h14};
    integer seed = 50;
    int errors = 0;
    int num_checks = 0;
    // Wire levels resolve between the device drive and the far side
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
    assign ms_in = (ms_oe & ms_out) | (~ms_oe & ms_ext);
    always #5 clk = ~clk;
    jsw_config_regs #(.FIXED_PATTERN(PAT), .REVISION(REV)) dut (.clk, .nrst,
        .master_clock(mck), .master_mode_select(mms), .master_data_in(mdi),
        .master_data_out(mdo), .config_mode(cmode), .instruction(ins), .capture_dr(cap_dr),
        .shift_dr(sh_dr), .update_dr(up_dr), .presence_scan_cmd(scan_cmd),
        .package_mode(pmode), .port_mode_select_in(ms_in), .port_data_return(ret),
        .port_mode_select_out(ms_out), .port_mode_select_oe(ms_oe),
        .port_serial_data_out(sd_out), .port_serial_data_oe(sd_oe),
        .port_test_reset_out(rst_out), .port_clock_out(ck_out), .aux_master_oe(aux_oe),
        .port_select_indicator_n(ind_n), .deselect_drive_select(dsel), .pin_in, .pin_out,
        .pin_oe);
    // single switch on the aux buses, so slave drive is never shared
    jsw_master_model m (.clk, .master_data_out(mdo), .master_clock(mck),
        .master_mode_select(mms), .master_data_in(mdi), .config_mode(cmode),
        .instruction(ins), .capture_dr(cap_dr), .shift_dr(sh_dr), .update_dr(up_dr));
    function automatic logic capable(logic [1:0] md, logic b5);
        return md == 2'h0 ? b5 : md == 2'h1;
    endfunction : capable
    function automatic logic [4:0] ind_exp(logic [4:0] s, logic c);
        return (s >= 5'h01 && s <= 5'h12) || (c && (s == 5'h13 || s == 5'h14)) ? ~s : 5'h1F;
    endfunction : ind_exp
    task automatic chk(input logic [19:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic check_path(input logic ck, ms, di);
        m.path(ck, ms, di);
        repeat (10) @(negedge clk);
        pn = ind_exp(sel, cap) == 5'h1F ? 5'h1F : sel - 5'h01;
        chk(20'(ind_n), 20'(ind_exp(sel, cap)));
        chk(20'({aux_oe, dsel}), 20'({cap, cap, cfg[4]}));
        for (int p = 0; p < 20; p++) begin
            e = 20'({3'h0, p < 18 ? {2{~cfg[4]}} : {cap, cap}, 1'b1});
            if (p == pn) begin
                e = 20'({ms ^ cfg[3], di ^ cfg[2], ck ^ cfg[0], 3'h7});
                chk(20'(mdo), 20'(ret[p] ^ cfg[1]));
            end
            chk(20'({ms_out[p], sd_out[p], ck_out[p], ms_oe[p], sd_oe[p], rst_out[p]}), e);
        end
    endtask : check_path
    initial begin
        #900000;
        errors++;
        report_and_stop();
    end
    initial begin
        {cfg, sel, pm} = 19'h0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (6) @(negedge clk);
        m.scan(jsw_pkg::INSTR_PRESENCE, 20, 20'hFFFFF, rd);
        chk(rd, jsw_pkg::PRESENCE_RESET);
        repeat (2) begin
            m.scan(jsw_pkg::INSTR_IDENT, 8, 20'($random(seed)), rd);
            chk(rd, 20'({PAT, REV}));
        end
        $display("reset and identity done");
        for (int k = 0; k < 24; k++) begin
            pmode = 2'(k / 3);
            {pcfg, psel, ppm} = {cfg, sel, pm};
            cfg = 6'($random(seed));
            sel = k < 10 ? corner[k] : 5'($random(seed));
            pm = 8'($random(seed));
            {ms_ext, ret, pin_ext} = {20'($random(seed)), 20'($random(seed)), 4'($random(seed))};
            cap = capable(pmode, cfg[5]);
            m.scan(jsw_pkg::INSTR_CONFIG, 6, 20'(cfg), rd);
            chk(rd, 20'(pcfg));
            m.scan(jsw_pkg::INSTR_SELECT, 5, 20'(sel), rd);
            chk(rd, 20'(psel));
            m.scan(jsw_pkg::INSTR_PIN_MODE, 8, 20'(pm), rd);
            chk(rd, 20'(ppm));
            for (int n = 0; n < 4; n++) begin
                drv = pm[2*n] ^ pm[2*n+1];
                es[n] = drv ? pm[2*n+1] : pin_ext[n];
                chk(20'({pin_oe[n], pin_oe[n] & pin_out[n]}), 20'({drv, drv & pm[2*n+1]}));
            end
            m.scan(jsw_pkg::INSTR_PIN_SENSE, 4, 20'($random(seed)), rd);
            chk(rd, 20'(es));
            scan_cmd = 1'b1;
            repeat (8) @(negedge clk);
            chk(ms_oe, 20'h0);
            scan_cmd = 1'b0;
            m.scan(jsw_pkg::INSTR_PRESENCE, 20, 20'($random(seed)), rd);
            chk(rd, {cap ? ms_ext[19:18] : 2'h0, ms_ext[17:0]});
            check_path(1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
            $display("round %0d done", k);
        end
        report_and_stop();
    end
endmodule : jsw_config_regs_tb
bind jsw_config_regs jsw_config_regs_checker chk_i (.clk, .nrst, .config_mode,
    .presence_scan_cmd, .port_mode_select_out, .port_mode_select_oe, .port_serial_data_oe,
    .port_test_reset_out, .port_clock_out, .aux_master_oe, .port_select_indicator_n,
    .deselect_drive_select);
